// ---- rtl/blk_boot_map_lock.sv ----
// Auxiliary control register, boot ROM map and lock level restrictions.
//
// Notes on behaviour
// - Pointer-select zero routes pointer operations to first pointer, one to second.
// - Boot-map enable maps boot ROM over F800h to FFFFh; clear unmaps it.
// - General user flag is freely written and read, with no hardware effect.
// - Bit 2 reads zero, ignores writes; it is never stored in the register.
// - Reserved bits read undefined; software must not write ones there.
// - Reset clears pointer-select and bit 2, bit 5 takes boot-loader jump bit.
// - Lock bit one means unprogrammed, zero means programmed.
// - All lock bits unprogrammed gives level 1 with no restrictions.
// - Level 2 blocks external code-table reads from internal memory.
// - From level 2 the external-access pin is latched at reset.
// - From level 2 parallel programming of flash and EEPROM is rejected.
// - In-system and firmware-call programming stay allowed at every level.
// - Level 3 adds blocking of parallel verify reads.
// - Level 4 adds blocking of execution from external program memory.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module blk_boot_map_lock
(
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Straps and pins
   input  wire logic        bootloader_jump_bit,
   input  wire logic        external_access_pin,
   // Core fetch and programmer requests
   input  wire logic [15:0] code_addr,
   input  wire logic        fetch_from_external,
   input  wire logic        code_table_read,
   input  wire logic        parallel_prog_req,
   input  wire logic        parallel_verify_req,
   input  wire logic        in_system_prog_req,
   input  wire logic        firmware_call_req,
   // Results
   output logic             use_second_data_pointer,
   output logic             boot_rom_selected,
   output logic             table_read_blocked,
   output logic             external_access_eff,
   output logic             prog_grant,
   output logic             verify_grant,
   output logic             external_exec_blocked
);
   logic [7:0]  aux_q;
   logic [7:0]  aux_d;
   logic [2:0]  lock_q;
   logic        rst_seen_q;
   logic        ea_latched_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic        ptr_q;
   logic        boot_q;
   logic        trb_q;
   logic        ea_q;
   logic        pg_q;
   logic        vg_q;
   logic        xeb_q;

   blk_level_if lv ();
   assign lv.lock_bits = lock_q;
   blk_level_decode u_decode
   (
      .lv (lv)
   );

   // Address decode and access qualification.
   wire setup     = psel & ~penable;
   wire sel_aux   = (paddr == blk_pkg::AUX_CONTROL_ONE_OFF);
   wire sel_lock  = (paddr == blk_pkg::LOCK_CONTROL_OFF);
   wire sel_level = (paddr == blk_pkg::LEVEL_STATUS_OFF);
   wire sel_ptr   = (paddr == blk_pkg::PTR_SELECT_OFF);
   wire mapped    = sel_aux | sel_lock | sel_level | sel_ptr;
   // Writes land at the edge that completes the access phase.
   wire access    = psel & penable & pready_q;
   wire wr_aux    = access & pwrite & sel_aux;
   wire wr_lock   = access & pwrite & sel_lock;

   // Only writable bits store; bit 2 and reserved bits are never stored.
   assign aux_d = wr_aux ? (pwdata[7:0] & blk_pkg::AUX_WRITE_MASK)
                         : aux_q;

   // Reserved bits read as zero, one legal undefined value.
   wire [7:0] aux_rd = aux_q & blk_pkg::AUX_WRITE_MASK;

   wire [31:0] rd_mux =
      sel_aux   ? {24'h000000, aux_rd} :
      sel_lock  ? {29'h0, lock_q} :
      sel_level ? {30'h0, lv.level} :
      sel_ptr   ? {31'h0, aux_q[blk_pkg::POINTER_SELECT_BIT]} :
                  32'h00000000;

   // Boot ROM decode over its fixed window.
   wire in_boot_win = (code_addr >= blk_pkg::BOOT_ROM_BASE) &&
                      (code_addr <= blk_pkg::BOOT_ROM_TOP);

   // Bit 5 catches the strap on the first edge after reset release.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         aux_q      <= blk_pkg::AUX_RESET_VALUE;
         rst_seen_q <= 1'b0;
      end
      else
      begin
         rst_seen_q <= 1'b1;
         if (!rst_seen_q)
         begin
            aux_q <= blk_pkg::AUX_RESET_VALUE;
            aux_q[blk_pkg::BOOT_MAP_BIT] <= bootloader_jump_bit;
         end
         else
         begin
            aux_q <= aux_d;
         end
      end
   end

   // Lock bits; a write may only program further (clear ones).
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lock_q <= blk_pkg::LOCK_RESET_VALUE;
      else if (wr_lock)
         lock_q <= lock_q & pwdata[2:0];
   end

   // External-access pin latched once after reset.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ea_latched_q <= 1'b0;
      else if (!rst_seen_q)
         ea_latched_q <= external_access_pin;
   end

   // APB answer: no wait state, ready in the first access-phase cycle.
   wire        pready_d  = setup;
   wire        pslverr_d = setup & ~mapped;
   wire [31:0] prdata_d  = (setup & ~pwrite) ? rd_mux : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready_q <= 1'b0;
      else
         pready_q <= pready_d;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pslverr_q <= 1'b0;
      else
         pslverr_q <= pslverr_d;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_q <= 32'h00000000;
      else
         prdata_q <= prdata_d;
   end

   // Next values of the registered results.
   wire ptr_d  = aux_q[blk_pkg::POINTER_SELECT_BIT];
   wire boot_d = aux_q[blk_pkg::BOOT_MAP_BIT] & in_boot_win;
   wire trb_d  = lv.table_read_block & code_table_read &
                 fetch_from_external;
   wire ea_d   = lv.pin_latch_mode ? ea_latched_q
                                   : external_access_pin;
   wire pg_d   = in_system_prog_req | firmware_call_req |
                 (parallel_prog_req & ~lv.parallel_prog_block);
   wire vg_d   = parallel_verify_req & ~lv.parallel_verify_block;
   wire xeb_d  = lv.external_exec_block & fetch_from_external;

   // Pointer select result.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ptr_q <= 1'b0;
      else
         ptr_q <= ptr_d;
   end

   // Boot ROM selection result.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         boot_q <= 1'b0;
      else
         boot_q <= boot_d;
   end

   // Blocked code-table read result.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trb_q <= 1'b0;
      else
         trb_q <= trb_d;
   end

   // Effective external-access level.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ea_q <= 1'b0;
      else
         ea_q <= ea_d;
   end

   // Programming grant.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pg_q <= 1'b0;
      else
         pg_q <= pg_d;
   end

   // Parallel verify grant.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         vg_q <= 1'b0;
      else
         vg_q <= vg_d;
   end

   // Blocked external execution result.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         xeb_q <= 1'b0;
      else
         xeb_q <= xeb_d;
   end

   assign prdata                  = prdata_q;
   assign pready                  = pready_q;
   assign pslverr                 = pslverr_q;
   assign use_second_data_pointer = ptr_q;
   assign boot_rom_selected       = boot_q;
   assign table_read_blocked      = trb_q;
   assign external_access_eff     = ea_q;
   assign prog_grant              = pg_q;
   assign verify_grant            = vg_q;
   assign external_exec_blocked   = xeb_q;
endmodule : blk_boot_map_lock

// ---- rtl/blk_level_decode.sv ----
// Decoder from three lock bits to a security level and its restrictions.
`timescale 1ns/1ps
module blk_level_decode
(
   blk_level_if.decoder lv
);
   wire lb0_prog = ~lv.lock_bits[0];
   wire lb1_prog = ~lv.lock_bits[1];
   wire lb2_prog = ~lv.lock_bits[2];
   // A zero lock bit is programmed; the highest programmed bit wins.
   assign lv.level = lb2_prog ? blk_pkg::BLK_LEVEL_FOUR :
                     lb1_prog ? blk_pkg::BLK_LEVEL_THREE :
                     lb0_prog ? blk_pkg::BLK_LEVEL_TWO :
                                blk_pkg::BLK_LEVEL_ONE;
   wire at_two   = (lv.level != blk_pkg::BLK_LEVEL_ONE);
   wire at_three = (lv.level == blk_pkg::BLK_LEVEL_THREE) ||
                   (lv.level == blk_pkg::BLK_LEVEL_FOUR);
   assign lv.table_read_block      = at_two;
   assign lv.pin_latch_mode        = at_two;
   assign lv.parallel_prog_block   = at_two;
   assign lv.parallel_verify_block = at_three;
   assign lv.external_exec_block   =
      (lv.level == blk_pkg::BLK_LEVEL_FOUR);
endmodule : blk_level_decode

// ---- rtl/blk_level_if.sv ----
// Interface carrying lock bits into the level decoder and its restrictions.
`timescale 1ns/1ps
interface blk_level_if;
   logic [2:0] lock_bits;
   logic [1:0] level;
   logic       table_read_block;
   logic       pin_latch_mode;
   logic       parallel_prog_block;
   logic       parallel_verify_block;
   logic       external_exec_block;
   modport decoder (input lock_bits, output level, table_read_block,
                    pin_latch_mode, parallel_prog_block,
                    parallel_verify_block, external_exec_block);
   modport user (output lock_bits, input level, table_read_block,
                 pin_latch_mode, parallel_prog_block,
                 parallel_verify_block, external_exec_block);
endinterface : blk_level_if

// ---- rtl/blk_pkg.sv ----
// Package with register map, field positions, reset values and level codes.
package blk_pkg;
   localparam logic [11:0] AUX_CONTROL_ONE_OFF = 12'h000;
   localparam logic [11:0] LOCK_CONTROL_OFF    = 12'h004;
   localparam logic [11:0] LEVEL_STATUS_OFF    = 12'h008;
   localparam logic [11:0] PTR_SELECT_OFF      = 12'h00c;
   localparam int unsigned POINTER_SELECT_BIT  = 0;
   localparam int unsigned STUCK_ZERO_BIT      = 2;
   localparam int unsigned GENERAL_FLAG_BIT    = 3;
   localparam int unsigned BOOT_MAP_BIT        = 5;
   localparam logic [7:0]  AUX_WRITE_MASK      = 8'h29;
   localparam logic [7:0]  AUX_RESERVED_MASK   = 8'hd2;
   localparam logic [7:0]  AUX_RESET_VALUE     = 8'h00;
   localparam logic [15:0] BOOT_ROM_BASE       = 16'hf800;
   localparam logic [15:0] BOOT_ROM_TOP        = 16'hffff;
   localparam logic [2:0]  LOCK_RESET_VALUE    = 3'h7;
   typedef enum logic [1:0]
   {
      BLK_LEVEL_ONE   = 2'b00,
      BLK_LEVEL_TWO   = 2'b01,
      BLK_LEVEL_THREE = 2'b10,
      BLK_LEVEL_FOUR  = 2'b11
   } blk_level_t;
endpackage : blk_pkg

// ---- verif/blk_bml_properties.sv ----
// Concurrent checks on the ports of the boot map and lock level block.
`timescale 1ns/1ps
module blk_bml_properties
(
   // Clock, reset and register bus
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Requests and results
   input wire logic [15:0] code_addr,
   input wire logic        in_system_prog_req,
   input wire logic        boot_rom_selected,
   input wire logic        prog_grant
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_boot_window: assert property (boot_rom_selected |->
      $past(code_addr) >= 16'hf800) else $error("boot map outside");
   chk_zero_bit: assert property (pready && !pwrite &&
      paddr == 12'h000 |-> !prdata[2]) else $error("bit 2 set");
   chk_isp_grant: assert property ($past(presetn) &&
      $past(in_system_prog_req) |-> prog_grant) else $error("no grant");
   chk_setup_answer: assert property (psel && !penable |=> pready)
      else $error("no ready");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held");
   chk_ready_phase: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   chk_unmapped_err: assert property (pready && paddr > 12'h00c |->
      pslverr && prdata == 32'h0) else $error("unmapped accepted");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   cover property (pslverr);
   cover property (boot_rom_selected);
   cover property (prog_grant && $past(in_system_prog_req));
endmodule : blk_bml_properties
bind blk_boot_map_lock blk_bml_properties u_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .code_addr,
   .in_system_prog_req, .boot_rom_selected, .prog_grant);

// ---- verif/blk_boot_map_lock_tb_top.sv ----
// Self-checking bench of the boot map and lock level block.
`timescale 1ns/1ps
module blk_boot_map_lock_tb_top;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, strap, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] addr;
   logic [6:0]  req;
   wire  [6:0]  res;
   int          failures, checks_done, lv;
   initial forever #2.5 pclk = ~pclk;
   blk_core_model u_core (.pclk, .addr, .req);
   blk_boot_map_lock u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .code_addr(addr),
      .bootloader_jump_bit(strap), .external_access_pin(req[6]),
      .fetch_from_external(req[5]), .code_table_read(req[4]),
      .parallel_prog_req(req[3]), .parallel_verify_req(req[2]),
      .in_system_prog_req(req[1]), .firmware_call_req(req[0]),
      .use_second_data_pointer(res[6]), .boot_rom_selected(res[5]),
      .table_read_blocked(res[4]), .external_access_eff(res[3]),
      .prog_grant(res[2]), .verify_grant(res[1]),
      .external_exec_blocked(res[0]));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      failures += (seen !== exp);
   endtask : check
   task automatic results;
      if (failures == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      check({31'h0, pready}, 32'h1);
      if (pready !== 1'b1)
         results();
      else
      begin
         rd = prdata;
         {psel, penable} <= 2'b00;
      end
   endtask : apb
   task automatic drive(input logic [15:0] a, input logic [6:0] r,
                        input int d);
      u_core.set(a, r, d);
      repeat (2) @(posedge pclk);
   endtask : drive
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      strap = 1'b1;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      check(rd & 32'h2d, 32'h20);
      apb(1'b1, 12'h000, 32'h2d);
      apb(1'b0, 12'h000, 32'h0);
      check(rd & 32'h2d, 32'h29);
      check(res[6], 1'b1);
      drive(16'hf800, 7'h40, 3);
      check(res[5], 1'b1);
      drive(16'hf7ff, 7'h40, 0);
      check(res[5], 1'b0);
      apb(1'b1, 12'h000, 32'h08);
      apb(1'b0, 12'h000, 32'h0);
      check(rd & 32'h2d, 32'h08);
      check(res[6], 1'b0);
      apb(1'b0, 12'h010, 32'h0);
      check(rd, 32'h0);
      for (lv = 0; lv < 4; lv++)
      begin
         apb(1'b1, 12'h004, {29'h0, lv < 3, lv < 2, lv == 0});
         apb(1'b0, 12'h008, 32'h0);
         check(rd, lv);
         drive(16'h0000, 7'h3c, 0);
         check(res[4:2], {lv>0, lv>0, lv==0});
         check(res[1:0], {lv < 2, lv == 3});
         drive(16'h0000, {5'h0, lv[0], !lv[0]}, 1);
         check(res[2], 1'b1);
      end
      u_core.set(16'h0000, 7'h40, 0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, 12'h004, 32'h5);
      apb(1'b0, 12'h008, 32'h0);
      check(rd, 32'h2);
      apb(1'b1, 12'h004, 32'h3);
      apb(1'b0, 12'h008, 32'h0);
      check(rd, 32'h3);
      results();
   end
endmodule : blk_boot_map_lock_tb_top

// ---- verif/blk_core_model.sv ----
// Request model of the processor core and the parallel programmer.
`timescale 1ns/1ps
module blk_core_model
(
   // Clock and requests
   input  wire logic        pclk,
   output logic      [15:0] addr,
   output logic      [6:0]  req
);
   initial {addr, req} = {16'h0000, 7'h40};
   task automatic set(input logic [15:0] a, input logic [6:0] r, input int d);
      repeat (d) @(posedge pclk);
      addr <= a;
      req <= r;
   endtask : set
endmodule : blk_core_model
